// file: bench/test_uosc_session_fifo_cfg.sv
// Self-checking bench for the session control and FIFO sizing block.
// Assumes a single AHB-Lite slave, so hready is tied to hreadyout.
`timescale 1ns/10ps
`default_nettype none
module test_uosc_session_fifo_cfg;
	logic clk_sys, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd, wd;
	logic [1:0] htrans, vbusCmd;
	logic [2:0] hsize;
	logic bRole, suspendCmd, driveVbus, srpStart, hnpStart;
	logic softDisconnect, hostRole, sessEnd, aValid, vValid;
	logic idPin, linkSuspend, hnpDone;
	logic [4:0] txM[8], rxM[8];
	int numErrors, totalChecks, srpSeen, idx;

	// Design and its far-side partner.
	uosc_session_fifo_cfg #(.EP_COUNT(4)) i_uosc_session_fifo_cfg (
		.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .vbusAboveSessEnd(sessEnd),
		.vbusAboveAValid(aValid), .vbusAboveValid(vValid),
		.idPin(idPin), .linkSuspend(linkSuspend), .hnpDone(hnpDone),
		.driveVbus(driveVbus), .srpStart(srpStart), .hnpStart(hnpStart),
		.softDisconnect(softDisconnect), .hostRole(hostRole));
	uosc_phy_model i_uosc_phy_model (
		.clk_sys(clk_sys), .rst(rst), .vbusCmd(vbusCmd), .bRole(bRole),
		.suspendCmd(suspendCmd), .srpStart(srpStart),
		.hnpStart(hnpStart), .vbusAboveSessEnd(sessEnd),
		.vbusAboveAValid(aValid), .vbusAboveValid(vValid),
		.idPin(idPin), .linkSuspend(linkSuspend), .hnpDone(hnpDone));

	// Clock source.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Count one-cycle session request pulses.
	always @(posedge clk_sys) begin
		if (srpStart === 1'b1) srpSeen++;
	end

	task automatic finishTest;
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Waits, bounded, until hready will be high at the coming edge.
	task automatic waitReady;
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		@(posedge clk_sys);
	endtask

	// One single-word transfer: address phase, then data phase.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= uosc_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= 3'h2;
		waitReady();
		htrans <= 2'h0;
		hwdata <= d;
		do @(negedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
		@(posedge clk_sys);
		hsel <= 1'b0;
	endtask

	function automatic logic [31:0] expSz(int i, logic [4:0] v);
		if (i == 0) return 32'h00000003;
		return (i >= 1 && i <= 4) ? {27'h0, v} : 32'h00000000;
	endfunction

	function automatic logic [31:0] expBy(logic [31:0] s);
		return 32'h00000001 << (s[3:0] + 3 + s[4]);
	endfunction

	task automatic devRd;
		bus(1'b0, uosc_pkg::OFF_DEVICE_CONTROL_REG, 32'h0, rd);
	endtask

	// Reads back both size registers of one index, and its byte counts for indices up to 4.
	task automatic fifoChk(input int i);
		logic [31:0] s;
		bus(1'b0, uosc_pkg::OFF_TXSIZE, 32'h0, s);
		chk("txSize", s, expSz(i, txM[i]));
		if (i <= 4) begin
			bus(1'b0, uosc_pkg::OFF_TXBYTES, 32'h0, rd);
			chk("txBytes", rd, expBy(expSz(i, txM[i])));
		end
		bus(1'b0, uosc_pkg::OFF_RXSIZE, 32'h0, s);
		chk("rxSize", s, expSz(i, rxM[i]));
		if (i <= 4) begin
			bus(1'b0, uosc_pkg::OFF_RXBYTES, 32'h0, rd);
			chk("rxBytes", rd, expBy(expSz(i, rxM[i])));
		end
	endtask

	// Hang guard, far beyond the roughly one thousand cycles the run needs.
	initial begin
		#300000;
		numErrors++;
		finishTest();
	end

	// Main sequence.
	initial begin
		hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0; vbusCmd = 2'h0; bRole = 1'b0;
		suspendCmd = 1'b0; rst = 1'b1; srpSeen = 0;
		numErrors = 0; totalChecks = 0;
		foreach (txM[i]) begin
			txM[i] = 5'h00;
			rxM[i] = 5'h00;
		end
		void'($urandom(30));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		cyc(4);
		devRd();
		chk("devctlReset", rd, 32'h0);
		bus(1'b0, 8'h20, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		for (int c = 0; c < 4; c++) begin
			vbusCmd <= 2'(c);
			cyc(6);
			devRd();
			chk("vbusCode", 32'(rd[4:3]), 32'(c));
		end
		vbusCmd <= 2'h0;
		// Software starts and ends an A session, ending it in suspend.
		bus(1'b1, uosc_pkg::OFF_DEVICE_CONTROL_REG, 32'h1, rd);
		cyc(4);
		devRd();
		chk("aSession", 32'(rd[0]), 32'h1);
		chk("aRole", 32'(rd[7]), 32'h0);
		chk("driveVbus", 32'(driveVbus), 32'h1);
		suspendCmd <= 1'b1;
		cyc(6);
		bus(1'b1, uosc_pkg::OFF_DEVICE_CONTROL_REG, 32'h0, rd);
		cyc(4);
		chk("softDisc", 32'(softDisconnect), 32'h1);
		devRd();
		chk("aSessionEnd", 32'(rd[0]), 32'h0);
		suspendCmd <= 1'b0;
		// B device requests a session with no bus power.
		bRole <= 1'b1;
		cyc(6);
		srpSeen = 0;
		bus(1'b1, uosc_pkg::OFF_DEVICE_CONTROL_REG, 32'h1, rd);
		cyc(20);
		chk("srpPulse", 32'(srpSeen), 32'h1);
		devRd();
		chk("bSession", 32'(rd[0]), 32'h1);
		chk("bRole", 32'(rd[7]), 32'h1);
		chk("softDiscClear", 32'(softDisconnect), 32'h0);
		vbusCmd <= 2'h3;
		cyc(4);
		// Host negotiation on suspend with the request bit set.
		bus(1'b1, uosc_pkg::OFF_DEVICE_CONTROL_REG, 32'h2, rd);
		suspendCmd <= 1'b1;
		cyc(25);
		chk("hostRole", 32'(hostRole), 32'h1);
		devRd();
		chk("hostBits", 32'(rd[2:1]), 32'h2);
		suspendCmd <= 1'b0;
		vbusCmd <= 2'h0;
		cyc(10);
		devRd();
		chk("bSessionEnd", 32'(rd[0]), 32'h0);
		chk("hostEnd", 32'(rd[2]), 32'h0);
		// Size settings, indices 0 to 7 first, then random ones.
		// Endpoints 1 to 4 each keep a setting of their own, none shared.
		for (int it = 0; it < 40; it++) begin
			idx = (it < 8) ? it : int'($urandom % 8);
			wd = (it < 2) ? 32'hFFFFFFFF : $urandom;
			bus(1'b1, uosc_pkg::OFF_EPINDEX, 32'(idx), rd);
			if (it % 2 == 1) begin
				bus(1'b1, uosc_pkg::OFF_TXSIZE, wd, rd);
				if (idx >= 1 && idx <= 4) txM[idx] = wd[4:0];
			end else begin
				bus(1'b1, uosc_pkg::OFF_RXSIZE, wd, rd);
				if (idx >= 1 && idx <= 4) rxM[idx] = wd[4:0];
			end
			fifoChk(idx);
		end
		finishTest();
	end
endmodule
`default_nettype wire

// file: bench/uosc_phy_model.sv
// Behavioural model of the transceiver and the USB peer on the OTG port.
// Assumes the bench sets bus level, role and suspend on clk_sys edges.
`timescale 1ns/10ps
`default_nettype none
module uosc_phy_model #(
	parameter int HNP_DELAY = 4,
	parameter int SRP_DELAY = 6
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Bench commands.
	input wire logic [1:0] vbusCmd,
	input wire logic bRole,
	input wire logic suspendCmd,
	// Requests from the controller.
	input wire logic srpStart,
	input wire logic hnpStart,
	// Transceiver pins.
	output logic vbusAboveSessEnd,
	output logic vbusAboveAValid,
	output logic vbusAboveValid,
	output logic idPin,
	output logic linkSuspend,
	output logic hnpDone
);
	logic [1:0] lvl;
	logic srpPower;
	int srpCnt;
	int hnpCnt;

	// The peer powers the bus a while after a session request and
	// finishes negotiation a while after it starts.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			srpCnt <= 0;
			srpPower <= 1'b0;
			hnpCnt <= 0;
		end else begin
			if (srpStart) begin
				srpCnt <= SRP_DELAY;
			end else if (srpCnt > 0) begin
				srpCnt <= srpCnt - 1;
			end
			if (srpCnt == 1) begin
				srpPower <= 1'b1;
			end else if (vbusCmd == 2'h3) begin
				srpPower <= 1'b0;
			end
			hnpCnt <= hnpStart ? hnpCnt + 1 : 0;
		end
	end

	// Comparators trip in rising order of the bus level.
	assign lvl = srpPower ? 2'h3 : vbusCmd;
	assign vbusAboveSessEnd = (lvl >= 2'h1);
	assign vbusAboveAValid = (lvl >= 2'h2);
	assign vbusAboveValid = (lvl == 2'h3);
	assign idPin = bRole;
	assign linkSuspend = suspendCmd;
	assign hnpDone = (hnpCnt >= HNP_DELAY);
endmodule
`default_nettype wire

// file: src/uosc_mem_if.sv
// Interface between the register logic and the endpoint size store.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface uosc_mem_if #(
	parameter int ADDR_W = 2,
	parameter int DATA_W = 5
);
	logic wrEn;
	logic wrRx;
	logic [ADDR_W-1:0] wrAddr;
	logic [DATA_W-1:0] wrData;
	logic [ADDR_W-1:0] rdAddr;
	logic [DATA_W-1:0] txRdData;
	logic [DATA_W-1:0] rxRdData;

	modport ctrl (output wrEn, wrRx, wrAddr, wrData, rdAddr,
		input txRdData, rxRdData);
	modport mem (input wrEn, wrRx, wrAddr, wrData, rdAddr,
		output txRdData, rxRdData);
endinterface
`default_nettype wire

// file: src/uosc_pkg.sv
// Constants and types shared by the session and FIFO sizing logic.
// Assumes a 32-bit AHB-Lite slave with an 8-bit register window.
package uosc_pkg;

	// Register byte offsets inside the slave window.
	localparam logic [7:0] OFF_DEVICE_CONTROL_REG = 8'h00;
	localparam logic [7:0] OFF_EPINDEX = 8'h04;
	localparam logic [7:0] OFF_TXSIZE = 8'h08;
	localparam logic [7:0] OFF_RXSIZE = 8'h0C;
	localparam logic [7:0] OFF_TXBYTES = 8'h10;
	localparam logic [7:0] OFF_RXBYTES = 8'h14;

	// Field positions of the device control register.
	localparam int BIT_SESSION = 0;
	localparam int BIT_HNPREQ = 1;
	localparam int BIT_HOST = 2;
	localparam int BIT_VBUS_LO = 3;
	localparam int BIT_VBUS_HI = 4;
	localparam int BIT_BROLE = 7;

	// Field positions of the endpoint FIFO size registers.
	localparam int BIT_DPB = 4;
	localparam int SZ_HI = 3;

	// Bus voltage level codes.
	localparam logic [1:0] VBUS_BELOW_END = 2'h0;
	localparam logic [1:0] VBUS_ABOVE_END = 2'h1;
	localparam logic [1:0] VBUS_ABOVE_AVALID = 2'h2;
	localparam logic [1:0] VBUS_ABOVE_VALID = 2'h3;

	// Endpoint range and the fixed control endpoint allocation.
	localparam logic [3:0] EP_FIRST = 4'h1;
	localparam logic [3:0] EP_LAST = 4'h4;
	localparam logic [3:0] EP_CONTROL = 4'h0;
	localparam logic [4:0] EP0_SIZE = 5'h03;
	localparam logic [4:0] SIZE_EXP_BASE = 5'h03;
	localparam logic [19:0] BYTES_ONE = 20'h00001;

	// Pin indices of the synchronised inputs.
	localparam int PIN_SESS_END = 0;
	localparam int PIN_AVALID = 1;
	localparam int PIN_VBUSVALID = 2;
	localparam int PIN_ID = 3;
	localparam int PIN_SUSPEND = 4;
	localparam int PIN_HNP_DONE = 5;
	localparam int PIN_COUNT = 6;

	// Bus encodings.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [2:0] {
		BUS_IDLE, BUS_WRITE, BUS_RWAIT, BUS_RLOAD, BUS_RDONE
	} uosc_bus_state_type;

	typedef enum logic [2:0] {
		SS_IDLE, SS_A_SESSION, SS_SRP, SS_B_SESSION, SS_B_HNP, SS_B_HOST
	} uosc_sess_state_type;

endpackage

// file: src/uosc_session_fifo_cfg.sv
// OTG session and role control with per-endpoint FIFO size settings.
// Assumes one AHB-Lite master, clk_sys at 100 MHz, and raw OTG status
// pins from the transceiver that need synchronising.
//
// Function
// - Bus voltage field reads 1, 2 or 3 for the three rising thresholds.
// - Bus voltage field sits in bits 4-3; 0 means below session end.
// - Bit 7 reads 0 for A device, 1 for B device.
// - Bit 2 is set while the controller acts as host.
// - B device with bit 1 set negotiates host on suspend, clears when done.
// - As B device, the controller sets and clears the session bit itself.
// - Software setting session starts session request; bus above session end completes it.
// - Clearing session while suspended performs a software disconnect.
// - Only endpoints 1 to 4 have configurable FIFO sizes.
// - Control endpoint has a fixed 64-byte FIFO at address 0.
// - Bit 4 of a size register selects double packet buffering.
// - Size is two to m+3 bytes single, m+4 bytes double buffered.
// - Encoded size is the largest packet accepted before bulk splitting.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module uosc_session_fifo_cfg #(
	parameter int EP_COUNT = 4
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Transceiver status pins.
	input wire logic vbusAboveSessEnd,
	input wire logic vbusAboveAValid,
	input wire logic vbusAboveValid,
	input wire logic idPin,
	input wire logic linkSuspend,
	input wire logic hnpDone,
	// Session controls towards the transceiver.
	output logic driveVbus,
	output logic srpStart,
	output logic hnpStart,
	output logic softDisconnect,
	output logic hostRole
);
	logic [uosc_pkg::PIN_COUNT-1:0] pinRaw;
	logic [uosc_pkg::PIN_COUNT-1:0] syncFirst;
	logic [uosc_pkg::PIN_COUNT-1:0] pinSync;
	uosc_pkg::uosc_bus_state_type busState, next_busState;
	uosc_pkg::uosc_sess_state_type sessState, next_sessState;
	logic [7:0] busAddr, next_busAddr;
	logic [31:0] next_hrdata, rdMux;
	logic [3:0] epIndex, next_epIndex;
	logic [1:0] vbusCode, next_vbusCode;
	logic hnpReq, next_hnpReq;
	logic suspendPrev, next_suspendPrev;
	logic next_srpStart, next_softDisconnect;
	logic accept, wrDevctl, wSess, epValid, bRole, suspendRise, sessionBit;
	logic [4:0] txSize, rxSize;
	logic [7:0] device_control_reg;

	uosc_mem_if #(.ADDR_W(2), .DATA_W(5)) memBus();

	uosc_size_mem #(.DEPTH(EP_COUNT), .DATA_W(5)) u_mem (
		.clk_sys(clk_sys),
		.rst(rst),
		.store(memBus.mem)
	);

	// Size in bytes of one endpoint FIFO from its double-buffer and code.
	function automatic logic [19:0] sizeBytes(input logic [4:0] v);
		logic [4:0] expo;
		expo = {1'b0, v[uosc_pkg::SZ_HI:0]} + uosc_pkg::SIZE_EXP_BASE
			+ {4'h0, v[uosc_pkg::BIT_DPB]};
		return uosc_pkg::BYTES_ONE << expo;
	endfunction

	// Status pins pass two flip-flops before any logic looks at them.
	assign pinRaw = {hnpDone, linkSuspend, idPin, vbusAboveValid,
		vbusAboveAValid, vbusAboveSessEnd};
	for (genvar p = 0; p < uosc_pkg::PIN_COUNT; p++) begin : g_sync
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				syncFirst[p] <= 1'b0;
				pinSync[p] <= 1'b0;
			end else begin
				syncFirst[p] <= pinRaw[p];
				pinSync[p] <= syncFirst[p];
			end
		end
	end

	// Decoded views of the synchronised pins and the bus.
	assign bRole = pinSync[uosc_pkg::PIN_ID];
	assign suspendRise = pinSync[uosc_pkg::PIN_SUSPEND] && !suspendPrev;
	assign accept = hsel && hready && htrans == uosc_pkg::HTRANS_NONSEQ;
	assign wrDevctl = busState == uosc_pkg::BUS_WRITE
		&& busAddr == uosc_pkg::OFF_DEVICE_CONTROL_REG;
	assign wSess = hwdata[uosc_pkg::BIT_SESSION];
	assign sessionBit = sessState != uosc_pkg::SS_IDLE;
	assign epValid = epIndex >= uosc_pkg::EP_FIRST
		&& epIndex <= uosc_pkg::EP_LAST;

	// Size store access uses the current endpoint index.
	assign memBus.rdAddr = 2'(epIndex - uosc_pkg::EP_FIRST);
	assign memBus.wrAddr = 2'(epIndex - uosc_pkg::EP_FIRST);
	assign memBus.wrData = hwdata[uosc_pkg::BIT_DPB:0];
	assign memBus.wrRx = busAddr == uosc_pkg::OFF_RXSIZE;
	assign memBus.wrEn = busState == uosc_pkg::BUS_WRITE && epValid
		&& (busAddr == uosc_pkg::OFF_TXSIZE
		|| busAddr == uosc_pkg::OFF_RXSIZE);

	// Endpoint 0 reads its fixed setting, unsupported endpoints read zero.
	assign txSize = epValid ? memBus.txRdData
		: (epIndex == uosc_pkg::EP_CONTROL ? uosc_pkg::EP0_SIZE : 5'h00);
	assign rxSize = epValid ? memBus.rxRdData
		: (epIndex == uosc_pkg::EP_CONTROL ? uosc_pkg::EP0_SIZE : 5'h00);

	// Device control image: role, voltage, host role, request and session.
	always_comb begin
		device_control_reg = 8'h00;
		device_control_reg[uosc_pkg::BIT_BROLE] = bRole;
		device_control_reg[uosc_pkg::BIT_VBUS_HI:uosc_pkg::BIT_VBUS_LO] = vbusCode;
		device_control_reg[uosc_pkg::BIT_HOST] = hostRole;
		device_control_reg[uosc_pkg::BIT_HNPREQ] = hnpReq;
		device_control_reg[uosc_pkg::BIT_SESSION] = sessionBit;
	end

	// Read data selection; unmapped offsets read zero.
	always_comb begin
		rdMux = 32'h0000_0000;
		if (busAddr == uosc_pkg::OFF_DEVICE_CONTROL_REG) begin
			rdMux = {24'h00_0000, device_control_reg};
		end else if (busAddr == uosc_pkg::OFF_EPINDEX) begin
			rdMux = {28'h000_0000, epIndex};
		end else if (busAddr == uosc_pkg::OFF_TXSIZE) begin
			rdMux = {27'h000_0000, txSize};
		end else if (busAddr == uosc_pkg::OFF_RXSIZE) begin
			rdMux = {27'h000_0000, rxSize};
		end else if (busAddr == uosc_pkg::OFF_TXBYTES) begin
			rdMux = {12'h000, sizeBytes(txSize)};
		end else if (busAddr == uosc_pkg::OFF_RXBYTES) begin
			rdMux = {12'h000, sizeBytes(rxSize)};
		end
	end

	// Bus sequencing: writes take no wait, reads two wait states.
	always_comb begin
		next_busState = uosc_pkg::BUS_IDLE;
		next_busAddr = busAddr;
		next_hrdata = hrdata;
		next_epIndex = epIndex;
		if (accept) begin
			next_busAddr = haddr[7:0];
			next_busState = hwrite ? uosc_pkg::BUS_WRITE : uosc_pkg::BUS_RWAIT;
		end else if (busState == uosc_pkg::BUS_RWAIT) begin
			next_busState = uosc_pkg::BUS_RLOAD;
		end else if (busState == uosc_pkg::BUS_RLOAD) begin
			next_busState = uosc_pkg::BUS_RDONE;
		end
		if (busState == uosc_pkg::BUS_RLOAD) begin
			next_hrdata = rdMux;
		end
		if (busState == uosc_pkg::BUS_WRITE
			&& busAddr == uosc_pkg::OFF_EPINDEX) begin
			next_epIndex = hwdata[3:0];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busState <= uosc_pkg::BUS_IDLE;
			busAddr <= 8'h00;
			hrdata <= 32'h0000_0000;
			epIndex <= 4'h0;
		end else begin
			busState <= next_busState;
			busAddr <= next_busAddr;
			hrdata <= next_hrdata;
			epIndex <= next_epIndex;
		end
	end

	assign hreadyout = busState != uosc_pkg::BUS_RWAIT
		&& busState != uosc_pkg::BUS_RLOAD;
	assign hresp = uosc_pkg::HRESP_OKAY;

	// Session and role sequencing.
	always_comb begin
		next_sessState = sessState;
		next_hnpReq = hnpReq;
		next_srpStart = 1'b0;
		next_softDisconnect = softDisconnect;
		next_suspendPrev = pinSync[uosc_pkg::PIN_SUSPEND];
		if (pinSync[uosc_pkg::PIN_VBUSVALID]) begin
			next_vbusCode = uosc_pkg::VBUS_ABOVE_VALID;
		end else if (pinSync[uosc_pkg::PIN_AVALID]) begin
			next_vbusCode = uosc_pkg::VBUS_ABOVE_AVALID;
		end else if (pinSync[uosc_pkg::PIN_SESS_END]) begin
			next_vbusCode = uosc_pkg::VBUS_ABOVE_END;
		end else begin
			next_vbusCode = uosc_pkg::VBUS_BELOW_END;
		end
		case (sessState)
			uosc_pkg::SS_IDLE: begin
				if (!bRole && wrDevctl && wSess) begin
					next_sessState = uosc_pkg::SS_A_SESSION;
					next_softDisconnect = 1'b0;
				end else if (bRole && vbusCode != uosc_pkg::VBUS_BELOW_END) begin
					next_sessState = uosc_pkg::SS_B_SESSION;
					next_softDisconnect = 1'b0;
				end else if (bRole && wrDevctl && wSess) begin
					next_sessState = uosc_pkg::SS_SRP;
					next_srpStart = 1'b1;
				end
			end
			uosc_pkg::SS_A_SESSION: begin
				if (bRole) begin
					next_sessState = uosc_pkg::SS_IDLE;
				end else if (wrDevctl && !wSess) begin
					next_sessState = uosc_pkg::SS_IDLE;
					next_softDisconnect = pinSync[uosc_pkg::PIN_SUSPEND];
				end
			end
			uosc_pkg::SS_SRP: begin
				if (vbusCode != uosc_pkg::VBUS_BELOW_END) begin
					next_sessState = uosc_pkg::SS_B_SESSION;
					next_softDisconnect = 1'b0;
				end else if (!bRole || (wrDevctl && !wSess)) begin
					next_sessState = uosc_pkg::SS_IDLE;
				end
			end
			uosc_pkg::SS_B_SESSION, uosc_pkg::SS_B_HOST: begin
				if (!bRole || vbusCode == uosc_pkg::VBUS_BELOW_END) begin
					next_sessState = uosc_pkg::SS_IDLE;
				end else if (wrDevctl && !wSess
					&& pinSync[uosc_pkg::PIN_SUSPEND]) begin
					next_sessState = uosc_pkg::SS_IDLE;
					next_softDisconnect = 1'b1;
				end else if (sessState == uosc_pkg::SS_B_SESSION
					&& hnpReq && suspendRise) begin
					next_sessState = uosc_pkg::SS_B_HNP;
				end
			end
			uosc_pkg::SS_B_HNP: begin
				if (!bRole || vbusCode == uosc_pkg::VBUS_BELOW_END) begin
					next_sessState = uosc_pkg::SS_IDLE;
				end else if (pinSync[uosc_pkg::PIN_HNP_DONE]) begin
					next_sessState = uosc_pkg::SS_B_HOST;
					next_hnpReq = 1'b0;
				end
			end
			default: begin
				next_sessState = uosc_pkg::SS_IDLE;
			end
		endcase
		// A software write of the request bit counts only for a B device.
		if (wrDevctl && bRole) begin
			next_hnpReq = hwdata[uosc_pkg::BIT_HNPREQ];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sessState <= uosc_pkg::SS_IDLE;
			hnpReq <= 1'b0;
			srpStart <= 1'b0;
			softDisconnect <= 1'b0;
			suspendPrev <= 1'b0;
			vbusCode <= uosc_pkg::VBUS_BELOW_END;
		end else begin
			sessState <= next_sessState;
			hnpReq <= next_hnpReq;
			srpStart <= next_srpStart;
			softDisconnect <= next_softDisconnect;
			suspendPrev <= next_suspendPrev;
			vbusCode <= next_vbusCode;
		end
	end

	// Role outputs follow the session state.
	assign hostRole = sessState == uosc_pkg::SS_A_SESSION
		|| sessState == uosc_pkg::SS_B_HOST;
	assign driveVbus = sessState == uosc_pkg::SS_A_SESSION;
	assign hnpStart = sessState == uosc_pkg::SS_B_HNP;

	// Checks on the behaviour above.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_read_addr;
		hsel && hready && htrans == uosc_pkg::HTRANS_NONSEQ && !hwrite;
	endsequence
	sequence s_read_data;
		!hreadyout ##1 !hreadyout ##1 hreadyout;
	endsequence

	a_read_wait: assert property (s_read_addr |=> s_read_data)
		else $error("Read did not complete after two wait states.");
	a_vbus_top: assert property (pinSync[uosc_pkg::PIN_VBUSVALID] |=>
		device_control_reg[uosc_pkg::BIT_VBUS_HI:uosc_pkg::BIT_VBUS_LO] == 2'h3)
		else $error("Bus voltage field not 3 above valid level.");
	a_vbus_low: assert property (pinSync[uosc_pkg::PIN_SESS_END] == 1'b0
		&& pinSync[uosc_pkg::PIN_AVALID] == 1'b0
		&& pinSync[uosc_pkg::PIN_VBUSVALID] == 1'b0 |=> vbusCode == 2'h0)
		else $error("Bus voltage field not 0 below session end.");
	a_role_bit: assert property (device_control_reg[uosc_pkg::BIT_BROLE] ==
		$past(idPin, 2))
		else $error("Role bit does not follow the identity pin.");
	a_host_entry: assert property ($rose(hostRole) |->
		sessionBit && ($past(sessState) == uosc_pkg::SS_B_HNP || !bRole))
		else $error("Host role entered without a session.");
	a_hnp_done: assert property (sessState == uosc_pkg::SS_B_HNP
		&& pinSync[uosc_pkg::PIN_HNP_DONE] && bRole && !wrDevctl
		&& vbusCode != 2'h0 |=> !hnpReq && hostRole && !hnpStart)
		else $error("Negotiation end did not clear request.");
	a_a_session: assert property (!bRole && wrDevctl && wSess
		&& sessState == uosc_pkg::SS_IDLE |=> sessionBit && driveVbus)
		else $error("A device session did not start on write.");
	a_srp_pulse: assert property (bRole && wrDevctl && wSess
		&& sessState == uosc_pkg::SS_IDLE && vbusCode == 2'h0
		|=> srpStart ##1 !srpStart)
		else $error("Session request pulse wrong.");
	a_soft_disc: assert property (bRole && wrDevctl && !wSess
		&& sessState == uosc_pkg::SS_B_SESSION && vbusCode != 2'h0
		&& pinSync[uosc_pkg::PIN_SUSPEND] |=> softDisconnect && !sessionBit)
		else $error("Software disconnect not performed.");
	a_ep_range: assert property (memBus.wrEn |->
		epIndex >= 4'h1 && epIndex <= 4'h4)
		else $error("Size write to unsupported endpoint.");
	a_ep0_fixed: assert property (busState == uosc_pkg::BUS_RLOAD
		&& busAddr == uosc_pkg::OFF_TXBYTES && epIndex == 4'h0
		|=> hrdata == 32'h0000_0040)
		else $error("Control endpoint size not 64 bytes.");
	a_reserved_zero: assert property (busState == uosc_pkg::BUS_RLOAD
		&& busAddr == uosc_pkg::OFF_RXSIZE |=> hrdata[31:5] == 27'h0)
		else $error("Reserved size bits not zero.");
endmodule
`default_nettype wire

// file: src/uosc_size_mem.sv
// Small store of transmit and receive size settings, one entry each
// per configurable endpoint. Read data come out of registers.
// Assumes clk_sys and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module uosc_size_mem #(
	parameter int DEPTH = 4,
	parameter int DATA_W = 5
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Access port.
	uosc_mem_if.mem store
);
	logic [DATA_W-1:0] txStore [DEPTH];
	logic [DATA_W-1:0] rxStore [DEPTH];
	logic [DATA_W-1:0] next_txStore [DEPTH];
	logic [DATA_W-1:0] next_rxStore [DEPTH];
	logic [DATA_W-1:0] txRd;
	logic [DATA_W-1:0] rxRd;
	logic [DATA_W-1:0] next_txRd;
	logic [DATA_W-1:0] next_rxRd;

	// Each entry takes a write when its address and direction match.
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_comb begin
			next_txStore[i] = txStore[i];
			next_rxStore[i] = rxStore[i];
			if (store.wrEn && store.wrAddr == i) begin
				if (store.wrRx) begin
					next_rxStore[i] = store.wrData;
				end else begin
					next_txStore[i] = store.wrData;
				end
			end
		end

		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				txStore[i] <= '0;
				rxStore[i] <= '0;
			end else begin
				txStore[i] <= next_txStore[i];
				rxStore[i] <= next_rxStore[i];
			end
		end
	end

	// The selected entries are registered every cycle.
	always_comb begin
		next_txRd = txStore[store.rdAddr];
		next_rxRd = rxStore[store.rdAddr];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			txRd <= '0;
			rxRd <= '0;
		end else begin
			txRd <= next_txRd;
			rxRd <= next_rxRd;
		end
	end

	assign store.txRdData = txRd;
	assign store.rxRdData = rxRd;
endmodule
`default_nettype wire
